// ==== rtl/gpio_defines.svh ====
/*
 * constants for the port pins and host select block: register offsets,
 * reset values, reserved read values, field positions and the default pad mode map.
 * assumes it is included by bare name from rtl/ and defines nothing else.
 */
`ifndef GPIO_DEFINES_SVH
`define GPIO_DEFINES_SVH

// special-function register offsets (8-bit space)
`define PORTB_VALUE_ADDR      8'hB0
`define PORTB_CFG_FIRST_ADDR  8'hFC
`define PORTB_CFG_SECOND_ADDR 8'hFD
`define PORTC_VALUE_ADDR      8'hD7

// configuration space offset (16-bit space)
`define HOST_SELECT_ADDR      16'h6103

// reset values
`define PORTB_VALUE_RST       6'h3F
`define PORTB_CFG_FIRST_RST   6'h3F
`define PORTB_CFG_SECOND_RST  6'h00
`define PORTC_VALUE_RST       2'h3
`define UNMAPPED_RDATA        8'h00

// reserved read values of the upper bits
`define PORTB_RSVD_READ       2'h3
`define CFG_FIRST_RSVD_READ   2'h3
`define CFG_SECOND_RSVD_READ  2'h0
`define PORTC_RSVD_READ       5'h1F

// port-B bit positions
`define PORTB_RX_BIT          0
`define PORTB_TX_BIT          1
`define PORTB_IRQ0_BIT        2
`define PORTB_IRQ1_BIT        3
`define PORTB_SCCLK_BIT       4
`define PORTB_PINS            6

// host select register fields
`define HSEL_IRQ_INV_BIT      7
`define HSEL_PIN_ONE_BIT      5
`define HSEL_PIN_ZERO_BIT     3
`define HSEL_ENABLE_BIT       2
`define HSEL_SEL_ONE_BIT      1
`define HSEL_SEL_ZERO_BIT     0

// pad mode per {second,first} cfg pair, two bits per entry, entry 0 lowest;
// reset pair {0,1} maps to quasi-bidirectional
`define PAD_MODE_MAP_DEFAULT  8'h72

`endif

// ==== rtl/gpio_pkg.sv ====
/*
 * types shared by the port pins and host select block.
 * assumes no other package; values stay in gpio_defines.svh.
 */
package gpio_pkg;

	// pad drive modes, encoded in declaration order
	typedef enum logic [1:0] {
		PAD_QUASI,
		PAD_PUSHPULL,
		PAD_INPUT,
		PAD_OPENDRAIN
	} pad_mode_t;

endpackage

// ==== rtl/pad_cell.sv ====
/*
 * one general-purpose pad driver: turns a latched value and a mode into
 * output, output enable and the weak pull-up and hold controls.
 * assumes the wire level is resolved outside from the enables.
 */
`timescale 1ns/1ps

module pad_cell (
	// clock and reset
	input  wire logic              clk_i,
	input  wire logic              rstn_i,
	input  wire logic              ce_i,
	// control
	input  wire gpio_pkg::pad_mode_t mode_i,
	input  wire logic              val_i,
	input  wire logic              wr_i,
	input  wire logic              pad_i,
	// pad side
	output logic                   pad_o,
	output logic                   pad_oe_o,
	output logic                   pullup_o,
	output logic                   hold_o
);

	logic kick_r;

	// one-cycle strong high after a write, latch already holds new value
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			kick_r <= 1'b0;
		end else if (ce_i) begin
			kick_r <= wr_i;
		end
	end

	// drive decode per mode
	always_comb begin
		pad_o    = 1'b0;
		pad_oe_o = 1'b0;
		pullup_o = 1'b0;
		hold_o   = 1'b0;
		unique case (mode_i)
			gpio_pkg::PAD_QUASI: begin
				pad_o    = val_i;
				pad_oe_o = ~val_i | kick_r;
				pullup_o = val_i;
				hold_o   = val_i & pad_i & ~kick_r; // hold only once pad is high
			end
			gpio_pkg::PAD_PUSHPULL: begin
				pad_o    = val_i;
				pad_oe_o = 1'b1;
			end
			gpio_pkg::PAD_INPUT: begin
				pad_oe_o = 1'b0;
			end
			gpio_pkg::PAD_OPENDRAIN: begin
				pad_o    = 1'b0;
				pad_oe_o = ~val_i;
			end
		endcase
	end

endmodule

// ==== rtl/port_pins_and_host_select.sv ====
/*
 * port-B and port-C general-purpose pins and the host interface select
 * register, reached by the cpu over its special-function port and its
 * configuration port.
 * assumes pad levels arrive synchronous to clk_i and the pad wire is
 * resolved outside from the output enables.
 */
`timescale 1ns/1ps
`include "gpio_defines.svh"

module port_pins_and_host_select #(
	parameter int          PORTB_PINS   = `PORTB_PINS,
	parameter logic [7:0]  PAD_MODE_MAP = `PAD_MODE_MAP_DEFAULT
) (
	// clock, reset, enable
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	input  wire logic        ce_i,
	// special-function register port
	input  wire logic [7:0]  sfr_addr_i,
	input  wire logic        sfr_wr_i,
	input  wire logic        sfr_rd_i,
	input  wire logic [7:0]  sfr_wdata_i,
	output logic      [7:0]  sfr_rdata_o,
	// configuration register port
	input  wire logic [15:0] cfg_addr_i,
	input  wire logic        cfg_wr_i,
	input  wire logic        cfg_rd_i,
	input  wire logic [7:0]  cfg_wdata_i,
	output logic      [7:0]  cfg_rdata_o,
	// port-B pads
	input  wire logic [5:0]  portb_pad_i,
	output logic      [5:0]  portb_pad_o,
	output logic      [5:0]  portb_pad_oe_o,
	output logic      [5:0]  portb_pullup_o,
	output logic      [5:0]  portb_hold_o,
	// port-B alternate functions
	input  wire logic        smartcard_clock_alt_en_i,
	input  wire logic        smartcard_clock_alt_i,
	input  wire logic        uart_tx_alt_en_i,
	input  wire logic        uart_tx_i,
	input  wire logic        uart_rx_alt_en_i,
	output logic             uart_rx_o,
	output logic             ext_irq_one_o,
	output logic             ext_irq_zero_o,
	// port-C pads and status
	input  wire logic        usb_ready_flag_i,
	input  wire logic        sda_pad_i,
	output logic             sda_pad_o,
	output logic             sda_pad_oe_o,
	output logic             scl_pad_o,
	output logic             scl_pad_oe_o,
	input  wire logic        shared_select_pad_i,
	// host select pins
	input  wire logic        select_pin_zero_i,
	input  wire logic        select_pin_one_i,
	// host interface side
	output logic             host_if_rst_o,
	output logic [1:0]       strap_sel_o,
	output logic             usb_en_o,
	output logic             usb_bus_powered_o,
	output logic             fast_serial_en_o,
	input  wire logic        usb_dp_i,
	input  wire logic        usb_dp_oe_i,
	input  wire logic        usb_dm_i,
	input  wire logic        usb_dm_oe_i,
	output logic             usb_dp_o,
	output logic             usb_dm_o,
	input  wire logic        fast_serial_tx_i,
	output logic             fast_serial_rx_o,
	// shared host pads
	input  wire logic        dp_pad_i,
	input  wire logic        dm_pad_i,
	output logic             dp_pad_o,
	output logic             dp_pad_oe_o,
	output logic             dm_pad_o,
	output logic             dm_pad_oe_o
);

	// the pin map below is hard-wired to six port-B pins
	if (PORTB_PINS != `PORTB_PINS) begin : g_bad_pins
		$error("port-B pin count must be six");
	end

	// register state
	logic [5:0] portb_val_r;
	logic [5:0] cfg_first_r;
	logic [5:0] cfg_second_r;
	logic [1:0] portc_val_r;
	logic       irq_inv_r;
	logic       sel_en_r;
	logic [1:0] selif_r;
	logic       strap_done_r;
	logic [1:0] strap_r;
	logic [7:0] sfr_rdata_r;
	logic [7:0] cfg_rdata_r;
	// decoded strobes, read muxes and pin takeover
	logic       portb_wr;
	logic       cfgf_wr;
	logic       cfgs_wr;
	logic       portc_wr;
	logic       hsel_wr;
	logic [7:0] sfr_rd_mux;
	logic [7:0] cfg_rd_mux;
	logic [5:0] alt_en;
	logic [5:0] alt_val;
	logic       serial_sel;
	logic       usb_sel;

	// write strobes, all gated by the clock enable
	assign portb_wr = ce_i & sfr_wr_i & (sfr_addr_i == `PORTB_VALUE_ADDR);
	assign cfgf_wr  = ce_i & sfr_wr_i & (sfr_addr_i == `PORTB_CFG_FIRST_ADDR);
	assign cfgs_wr  = ce_i & sfr_wr_i & (sfr_addr_i == `PORTB_CFG_SECOND_ADDR);
	assign portc_wr = ce_i & sfr_wr_i & (sfr_addr_i == `PORTC_VALUE_ADDR);
	assign hsel_wr  = ce_i & cfg_wr_i & (cfg_addr_i == `HOST_SELECT_ADDR);

	// port-B output latch; bits 7:6 have no storage so writes vanish
	// reads never see this latch: a pin held low outside reads 0
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			portb_val_r <= `PORTB_VALUE_RST;
		end else if (portb_wr) begin
			portb_val_r <= sfr_wdata_i[5:0];
		end
	end

	// port-B configuration pairs
	// a new mode acts on the next cycle; no kick goes with it,
	// so a pin switched to quasi at one just floats up weakly
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cfg_first_r  <= `PORTB_CFG_FIRST_RST;
			cfg_second_r <= `PORTB_CFG_SECOND_RST;
		end else begin
			if (cfgf_wr) begin
				cfg_first_r <= sfr_wdata_i[5:0];
			end
			if (cfgs_wr) begin
				cfg_second_r <= sfr_wdata_i[5:0];
			end
		end
	end

	// port-C latch, only the two pad bits are writable
	// no mode pair here: the pads are open-drain by construction
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			portc_val_r <= `PORTC_VALUE_RST;
		end else if (portc_wr) begin
			portc_val_r <= sfr_wdata_i[1:0];
		end
	end

	// host select register; pin level bits are read-only views
	// bits 6 to 3 take no storage, a write to them is lost
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_inv_r <= 1'b0;
			sel_en_r  <= 1'b0;
			selif_r   <= 2'h0;
		end else if (hsel_wr) begin
			irq_inv_r <= cfg_wdata_i[`HSEL_IRQ_INV_BIT];
			sel_en_r  <= cfg_wdata_i[`HSEL_ENABLE_BIT];
			selif_r   <= {cfg_wdata_i[`HSEL_SEL_ONE_BIT], cfg_wdata_i[`HSEL_SEL_ZERO_BIT]};
		end
	end

	// strap capture at the first enabled edge after reset release;
	// host interfaces stay in reset until then
	// the strap is only reported; firmware must still copy it
	// into the select field before it sets the enable
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			strap_done_r <= 1'b0;
			strap_r      <= 2'h0;
		end else if (ce_i && !strap_done_r) begin
			strap_done_r <= 1'b1;
			strap_r      <= {select_pin_one_i, select_pin_zero_i};
		end
	end

	assign host_if_rst_o = ~strap_done_r;
	assign strap_sel_o   = strap_r;

	// alternate functions that take port-B pins over
	// the receive alternate only needs the pin released; its level
	// reaches the core through uart_rx_o like any other read
	assign alt_en  = {1'b0, smartcard_clock_alt_en_i, 2'b00, uart_tx_alt_en_i, uart_rx_alt_en_i};
	assign alt_val = {1'b0, smartcard_clock_alt_i, 2'b00, uart_tx_i, 1'b0};

	// one driver per port-B pin; alt functions pick their own mode
	for (genvar i = 0; i < `PORTB_PINS; i++) begin : g_portb
		logic [2:0]          map_idx;
		gpio_pkg::pad_mode_t cfg_mode;
		gpio_pkg::pad_mode_t eff_mode;
		logic                eff_val;

		assign map_idx  = {cfg_second_r[i], cfg_first_r[i], 1'b0};
		assign cfg_mode = gpio_pkg::pad_mode_t'(PAD_MODE_MAP[map_idx +: 2]);

		// receive pin goes input, clock and transmit push-pull
		always_comb begin
			eff_mode = cfg_mode;
			eff_val  = portb_val_r[i];
			if (alt_en[i]) begin
				eff_val  = alt_val[i];
				eff_mode = (i == `PORTB_RX_BIT) ? gpio_pkg::PAD_INPUT : gpio_pkg::PAD_PUSHPULL;
			end
		end

		// an owned pin gets no kick, so handing it back later
		// cannot flash a strong one onto the wire
		pad_cell u_pad (
			.clk_i    (clk_i),
			.rstn_i   (rstn_i),
			.ce_i     (ce_i),
			.mode_i   (eff_mode),
			.val_i    (eff_val),
			.wr_i     (portb_wr & ~alt_en[i]),
			.pad_i    (portb_pad_i[i]),
			.pad_o    (portb_pad_o[i]),
			.pad_oe_o (portb_pad_oe_o[i]),
			.pullup_o (portb_pullup_o[i]),
			.hold_o   (portb_hold_o[i])
		);
	end

	// pin levels toward the cpu core
	assign uart_rx_o      = portb_pad_i[`PORTB_RX_BIT];
	assign ext_irq_zero_o = portb_pad_i[`PORTB_IRQ0_BIT];
	assign ext_irq_one_o  = portb_pad_i[`PORTB_IRQ1_BIT] ^ irq_inv_r;

	// port-C pads are open-drain: never drive a one, pull-up gives it
	assign sda_pad_o    = 1'b0;
	assign sda_pad_oe_o = ~portc_val_r[1];
	assign scl_pad_o    = 1'b0;
	assign scl_pad_oe_o = ~portc_val_r[0];

	// host interface decode; one field so at most one is ever on
	// strap gating keeps both hosts quiet until the pins are in
	assign serial_sel        = sel_en_r & ~selif_r[0];
	assign usb_sel           = sel_en_r & selif_r[0];
	assign fast_serial_en_o  = serial_sel & strap_done_r;
	assign usb_en_o          = usb_sel & strap_done_r;
	assign usb_bus_powered_o = usb_sel & selif_r[1] & strap_done_r;

	// shared pad mux; disabled select leaves both pads undriven
	// usb keeps its own enables, serial always drives dm
	always_comb begin
		dp_pad_o    = 1'b0;
		dp_pad_oe_o = 1'b0;
		dm_pad_o    = 1'b0;
		dm_pad_oe_o = 1'b0;
		if (fast_serial_en_o) begin
			dm_pad_o    = fast_serial_tx_i;
			dm_pad_oe_o = 1'b1;
		end else if (usb_en_o) begin
			dp_pad_o    = usb_dp_i;
			dp_pad_oe_o = usb_dp_oe_i;
			dm_pad_o    = usb_dm_i;
			dm_pad_oe_o = usb_dm_oe_i;
		end
	end

	// receive lines; idle high on serial so a quiet line is no start bit
	assign fast_serial_rx_o = fast_serial_en_o ? dp_pad_i : 1'b1;
	assign usb_dp_o         = usb_en_o ? dp_pad_i : 1'b0;
	assign usb_dm_o         = usb_en_o ? dm_pad_i : 1'b0;

	// special-function read mux: value bits always show the live pins
	// unmapped addresses read zero so a stray read is harmless
	always_comb begin
		unique case (sfr_addr_i)
			`PORTB_VALUE_ADDR:      sfr_rd_mux = {`PORTB_RSVD_READ, portb_pad_i};
			`PORTB_CFG_FIRST_ADDR:  sfr_rd_mux = {`CFG_FIRST_RSVD_READ, cfg_first_r};
			`PORTB_CFG_SECOND_ADDR: sfr_rd_mux = {`CFG_SECOND_RSVD_READ, cfg_second_r};
			`PORTC_VALUE_ADDR:      sfr_rd_mux = {`PORTC_RSVD_READ, usb_ready_flag_i,
			                                      sda_pad_i, shared_select_pad_i};
			default:                sfr_rd_mux = `UNMAPPED_RDATA;
		endcase
	end

	// configuration read mux
	// pin-level bits are live; reserved bits 6 and 4 read zero
	always_comb begin
		cfg_rd_mux = `UNMAPPED_RDATA;
		if (cfg_addr_i == `HOST_SELECT_ADDR) begin
			cfg_rd_mux[`HSEL_IRQ_INV_BIT]  = irq_inv_r;
			cfg_rd_mux[`HSEL_PIN_ONE_BIT]  = select_pin_one_i;
			cfg_rd_mux[`HSEL_PIN_ZERO_BIT] = select_pin_zero_i;
			cfg_rd_mux[`HSEL_ENABLE_BIT]   = sel_en_r;
			cfg_rd_mux[`HSEL_SEL_ONE_BIT]  = selif_r[1];
			cfg_rd_mux[`HSEL_SEL_ZERO_BIT] = selif_r[0];
		end
	end

	// read data registered; stays until the next read
	// a pin that moves after the read edge cannot tear the byte
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sfr_rdata_r <= 8'h00;
		end else if (ce_i && sfr_rd_i) begin
			sfr_rdata_r <= sfr_rd_mux;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cfg_rdata_r <= 8'h00;
		end else if (ce_i && cfg_rd_i) begin
			cfg_rdata_r <= cfg_rd_mux;
		end
	end

	assign sfr_rdata_o = sfr_rdata_r;
	assign cfg_rdata_o = cfg_rdata_r;

endmodule

// ==== test/pin_partner.sv ====
/* far side of the port pins: resolves every pad wire but scl from the design
   enables, the far-side drivers and the board pull-ups.
   assumes the bench drives the far-side inputs just after a clock edge. */
`timescale 1ns/1ps

module pin_partner (
	// clock
	input  wire logic       clk_i,
	// design pad side
	input  wire logic [5:0] b_o_i, b_oe_i, b_weak_i,
	input  wire logic       sda_oe_i, dp_o_i, dp_oe_i, dm_o_i, dm_oe_i,
	// far-side drivers
	input  wire logic [5:0] ext_oe_i, ext_i,
	input  wire logic       sda_low_i, host_tx_i,
	// resolved levels
	output logic      [5:0] b_lvl_o,
	output logic            sda_lvl_o, dp_lvl_o, dm_lvl_o
);
	logic [5:0] float_r = 6'h15;

	// a released pin with no pull wanders, so a stale level never reads as valid
	always_ff @(posedge clk_i) begin
		float_r <= ~b_lvl_o;
	end

	// design drive wins, then the far side, then weak pull or hold
	always_comb begin
		b_lvl_o = (b_oe_i & b_o_i) | (~b_oe_i & ext_oe_i & ext_i) | (~b_oe_i & ~ext_oe_i & (b_weak_i | float_r));
		sda_lvl_o = !sda_oe_i && !sda_low_i;
		dp_lvl_o = dp_oe_i ? dp_o_i : host_tx_i;
		dm_lvl_o = dm_oe_i ? dm_o_i : ~dp_lvl_o;
	end
endmodule

// ==== test/port_pins_and_host_select_properties.sv ====
/* concurrent checks on the port pins and host select block.
   assumes it sees only the top ports and the defines header is reachable. */
`timescale 1ns/1ps
`include "gpio_defines.svh"

module port_pins_and_host_select_properties #(
	parameter int         PORTB_PINS   = `PORTB_PINS,
	parameter logic [7:0] PAD_MODE_MAP = `PAD_MODE_MAP_DEFAULT
) (
	// clock and register ports
	input wire logic        clk_i, rstn_i, ce_i, sfr_wr_i, sfr_rd_i, cfg_wr_i, cfg_rd_i,
	input wire logic [7:0]  sfr_addr_i, sfr_wdata_i, sfr_rdata_o, cfg_wdata_i, cfg_rdata_o,
	input wire logic [15:0] cfg_addr_i,
	// pads and alternate functions
	input wire logic [5:0]  portb_pad_i, portb_pad_o, portb_pad_oe_o,
	input wire logic        smartcard_clock_alt_en_i, smartcard_clock_alt_i, uart_tx_alt_en_i, uart_tx_i,
	input wire logic        uart_rx_alt_en_i, uart_rx_o, ext_irq_one_o, usb_ready_flag_i, sda_pad_i,
	input wire logic        sda_pad_o, sda_pad_oe_o, scl_pad_o, scl_pad_oe_o, shared_select_pad_i,
	// host side
	input wire logic        select_pin_zero_i, select_pin_one_i, host_if_rst_o, usb_en_o, fast_serial_en_o,
	input wire logic [1:0]  strap_sel_o,
	input wire logic        usb_dp_oe_i, usb_dm_oe_i, usb_dp_o, fast_serial_tx_i, fast_serial_rx_o,
	input wire logic        dp_pad_i, dp_pad_oe_o, dm_pad_o, dm_pad_oe_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	// accepted requests on each register port
	sequence s_sfr(wr, a);
		ce_i && (wr ? sfr_wr_i : sfr_rd_i) && sfr_addr_i == a;
	endsequence
	sequence s_cfg(wr);
		ce_i && (wr ? cfg_wr_i : cfg_rd_i) && cfg_addr_i == `HOST_SELECT_ADDR;
	endsequence

	property p_portb_read;
		s_sfr(0, `PORTB_VALUE_ADDR) |=> sfr_rdata_o == {`PORTB_RSVD_READ, $past(portb_pad_i)};
	endproperty
	a_portb_read: assert property (p_portb_read) else $error("port b read not the pin levels");
	property p_portc_read;
		s_sfr(0, `PORTC_VALUE_ADDR) |=> sfr_rdata_o ==
			{`PORTC_RSVD_READ, $past(usb_ready_flag_i), $past(sda_pad_i), $past(shared_select_pad_i)};
	endproperty
	a_portc_read: assert property (p_portc_read) else $error("port c read wrong");
	property p_portc_od;
		s_sfr(1, `PORTC_VALUE_ADDR) |=> sda_pad_oe_o == !$past(sfr_wdata_i[1])
			&& scl_pad_oe_o == !$past(sfr_wdata_i[0]) && !sda_pad_o && !scl_pad_o;
	endproperty
	a_portc_od: assert property (p_portc_od) else $error("port c not open drain");
	property p_smartcard;
		smartcard_clock_alt_en_i |-> portb_pad_oe_o[4] && portb_pad_o[4] == smartcard_clock_alt_i;
	endproperty
	a_smartcard: assert property (p_smartcard) else $error("smartcard clock not on pin");
	property p_uart_tx;
		uart_tx_alt_en_i |-> portb_pad_oe_o[1] && portb_pad_o[1] == uart_tx_i;
	endproperty
	a_uart_tx: assert property (p_uart_tx) else $error("serial transmit not on pin");
	property p_uart_rx;
		uart_rx_alt_en_i |-> !portb_pad_oe_o[0] && uart_rx_o == portb_pad_i[0];
	endproperty
	a_uart_rx: assert property (p_uart_rx) else $error("serial receive pin driven");
	property p_irq_inv;
		s_cfg(1) |=> ext_irq_one_o == (portb_pad_i[3] ^ $past(cfg_wdata_i[7]));
	endproperty
	a_irq_inv: assert property (p_irq_inv) else $error("interrupt one polarity wrong");
	property p_cfg_read;
		s_cfg(0) |=> cfg_rdata_o[5] == $past(select_pin_one_i) && cfg_rdata_o[3] == $past(select_pin_zero_i)
			&& !cfg_rdata_o[6] && !cfg_rdata_o[4];
	endproperty
	a_cfg_read: assert property (p_cfg_read) else $error("select pin read wrong");
	property p_sel_decode;
		(s_cfg(1) and !host_if_rst_o) |=> usb_en_o == ($past(cfg_wdata_i[2]) && $past(cfg_wdata_i[0]))
			&& fast_serial_en_o == ($past(cfg_wdata_i[2]) && !$past(cfg_wdata_i[0]));
	endproperty
	a_sel_decode: assert property (p_sel_decode) else $error("host select decode wrong");
	property p_exclusive;
		!(usb_en_o && fast_serial_en_o);
	endproperty
	a_exclusive: assert property (p_exclusive) else $error("two hosts on");
	property p_mux_off;
		!usb_en_o && !fast_serial_en_o |-> !dp_pad_oe_o && !dm_pad_oe_o;
	endproperty
	a_mux_off: assert property (p_mux_off) else $error("host pads driven while off");
	property p_serial_pads;
		fast_serial_en_o |-> dm_pad_oe_o && !dp_pad_oe_o && dm_pad_o == fast_serial_tx_i
			&& fast_serial_rx_o == dp_pad_i;
	endproperty
	a_serial_pads: assert property (p_serial_pads) else $error("serial pads wrong");
	property p_usb_pass;
		usb_en_o |-> dp_pad_oe_o == usb_dp_oe_i && dm_pad_oe_o == usb_dm_oe_i && usb_dp_o == dp_pad_i;
	endproperty
	a_usb_pass: assert property (p_usb_pass) else $error("usb pads not passed");
	property p_strap;
		$fell(host_if_rst_o) |-> strap_sel_o == {$past(select_pin_one_i), $past(select_pin_zero_i)};
	endproperty
	a_strap: assert property (p_strap) else $error("strap not captured");
endmodule

bind port_pins_and_host_select port_pins_and_host_select_properties #(
	.PORTB_PINS(PORTB_PINS), .PAD_MODE_MAP(PAD_MODE_MAP)) chk_inst (.*);

// ==== test/tb_top.sv ====
/* self-checking bench: register traffic, pad modes, alternate functions,
   port c and host select decode.
   assumes the partner model resolves every pad wire but scl. */
`timescale 1ns/1ps
`include "gpio_defines.svh"

module tb_top;
	logic        clk_i = 1'b0, rstn_i = 1'b0, ce_i = 1'b1, sfr_wr_i = 1'b0, sfr_rd_i = 1'b0;
	logic        cfg_wr_i = 1'b0, cfg_rd_i = 1'b0;
	logic [7:0]  sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, cfg_wdata_i = 8'h00, sfr_rdata_o, cfg_rdata_o, rd, v;
	logic [15:0] cfg_addr_i = 16'h0000;
	logic [5:0]  portb_pad_i, portb_pad_o, portb_pad_oe_o, portb_pullup_o, portb_hold_o;
	logic [5:0]  ext_oe = 6'h00, ext_v = 6'h00;
	logic        sc_en = 1'b0, sc_v = 1'b0, tx_en = 1'b0, tx_v = 1'b0, rx_en = 1'b0, usb_rdy = 1'b0;
	logic        uart_rx_o, ext_irq_one_o, ext_irq_zero_o, sda_pad_i, sda_pad_o, sda_pad_oe_o, scl_pad_o;
	logic        scl_pad_oe_o, shared_select_pad = 1'b0, pin0 = 1'b1, pin1 = 1'b0, sda_low = 1'b0, host_tx = 1'b0, fs_tx = 1'b0;
	logic        host_if_rst_o, usb_en_o, usb_bus_powered_o, fast_serial_en_o, usb_dp_o, usb_dm_o, fast_serial_rx_o;
	logic [1:0]  strap_sel_o;
	logic [3:0]  usb_drv = 4'h0;
	logic        dp_exp;
	logic        dp_pad_i, dm_pad_i, dp_pad_o, dp_pad_oe_o, dm_pad_o, dm_pad_oe_o;
	int          fail_count = 0, checked = 0, cyc = 0;

	// design and the pins around it
	port_pins_and_host_select port_pins_and_host_select_inst (.clk_i, .rstn_i, .ce_i, .sfr_addr_i, .sfr_wr_i,
		.sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o, .cfg_addr_i, .cfg_wr_i, .cfg_rd_i, .cfg_wdata_i, .cfg_rdata_o,
		.portb_pad_i, .portb_pad_o, .portb_pad_oe_o, .portb_pullup_o, .portb_hold_o,
		.smartcard_clock_alt_en_i(sc_en), .smartcard_clock_alt_i(sc_v), .uart_tx_alt_en_i(tx_en), .uart_tx_i(tx_v),
		.uart_rx_alt_en_i(rx_en), .uart_rx_o, .ext_irq_one_o, .ext_irq_zero_o, .usb_ready_flag_i(usb_rdy),
		.sda_pad_i, .sda_pad_o, .sda_pad_oe_o, .scl_pad_o, .scl_pad_oe_o, .shared_select_pad_i(shared_select_pad),
		.select_pin_zero_i(pin0), .select_pin_one_i(pin1), .host_if_rst_o, .strap_sel_o, .usb_en_o,
		.usb_bus_powered_o, .fast_serial_en_o, .usb_dp_i(usb_drv[0]), .usb_dp_oe_i(usb_drv[1]),
		.usb_dm_i(usb_drv[2]), .usb_dm_oe_i(usb_drv[3]), .usb_dp_o, .usb_dm_o, .fast_serial_tx_i(fs_tx),
		.fast_serial_rx_o, .dp_pad_i, .dm_pad_i, .dp_pad_o, .dp_pad_oe_o, .dm_pad_o, .dm_pad_oe_o);
	pin_partner pin_partner_inst (.clk_i, .b_o_i(portb_pad_o), .b_oe_i(portb_pad_oe_o),
		.b_weak_i(portb_pullup_o | portb_hold_o), .sda_oe_i(sda_pad_oe_o), .dp_o_i(dp_pad_o), .dp_oe_i(dp_pad_oe_o),
		.dm_o_i(dm_pad_o), .dm_oe_i(dm_pad_oe_o), .ext_oe_i(ext_oe), .ext_i(ext_v), .sda_low_i(sda_low),
		.host_tx_i(host_tx), .b_lvl_o(portb_pad_i), .sda_lvl_o(sda_pad_i), .dp_lvl_o(dp_pad_i), .dm_lvl_o(dm_pad_i));

	// 40 MHz clock
	initial begin
		forever #12.5 clk_i = ~clk_i;
	end

	// hang guard, far above the few hundred cycles the run needs
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			results();
		end
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one access on either port; read data lands in rd one cycle later
	task automatic acc(input logic cfg, input logic wr, input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_i);
		#2;
		sfr_addr_i = a[7:0];
		cfg_addr_i = a;
		sfr_wdata_i = d;
		cfg_wdata_i = d;
		sfr_wr_i = !cfg && wr;
		sfr_rd_i = !cfg && !wr;
		cfg_wr_i = cfg && wr;
		cfg_rd_i = cfg && !wr;
		@(posedge clk_i);
		#2;
		{sfr_wr_i, sfr_rd_i, cfg_wr_i, cfg_rd_i} = 4'h0;
		rd = cfg ? cfg_rdata_o : sfr_rdata_o;
	endtask

	// {enable, level} of one pin for mode {second,first}; kick marks the cycle after a write
	function automatic logic [1:0] exp_pad(input logic [1:0] m, input logic b, input logic kick);
		case (m)
			2'b00: return 2'b00;
			2'b01: return {!b || kick, b};
			2'b10: return {!b, 1'b0};
			default: return {1'b1, b};
		endcase
	endfunction

	task automatic pads(input logic [1:0] m, input logic [5:0] b, input logic kick);
		logic [5:0] oe, lv;
		for (int i = 0; i < 6; i++) begin
			{oe[i], lv[i]} = exp_pad(m, b[i], kick);
		end
		chk({2'b00, portb_pad_oe_o}, {2'b00, oe});
		chk({2'b00, portb_pad_o & portb_pad_oe_o}, {2'b00, lv & oe});
		if (m == 2'b00) chk({2'b00, portb_pullup_o | portb_hold_o}, 8'h00);
		if (m == 2'b01 && !kick) chk({2'b00, portb_pullup_o & b}, {2'b00, b});
	endtask

	task automatic results();
		if (fail_count == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		void'($urandom(32'h4e1522a9));
		repeat (8) @(posedge clk_i);
		#2;
		rstn_i = 1'b1;
		chk({1'b0, host_if_rst_o, portb_pad_oe_o}, 8'h40);
		acc(0, 0, `PORTB_CFG_FIRST_ADDR, 8'h00);
		chk(rd, 8'hFF);
		chk({6'h00, strap_sel_o}, {6'h00, pin1, pin0});
		acc(0, 0, `PORTB_VALUE_ADDR, 8'h00);
		chk(rd, 8'hFF);
		acc(0, 0, `PORTC_VALUE_ADDR, 8'h00);
		chk(rd, 8'hFA);
		// every pad mode, random latch values, reserved bits poked
		for (int m = 0; m < 4; m++) begin
			ext_oe = (m == 0) ? 6'h3F : 6'h00;
			ext_v = 6'($urandom);
			acc(0, 1, `PORTB_CFG_FIRST_ADDR, {8{m[0]}});
			acc(0, 1, `PORTB_CFG_SECOND_ADDR, {8{m[1]}});
			acc(0, 0, `PORTB_CFG_FIRST_ADDR, 8'h00);
			chk(rd, {2'b11, {6{m[0]}}});
			acc(0, 0, `PORTB_CFG_SECOND_ADDR, 8'h00);
			chk(rd, {2'b00, {6{m[1]}}});
			repeat (3) begin
				v = 8'($urandom);
				acc(0, 1, `PORTB_VALUE_ADDR, v);
				pads(m[1:0], v[5:0], 1'b1);
				@(posedge clk_i);
				#2;
				pads(m[1:0], v[5:0], 1'b0);
				acc(0, 0, `PORTB_VALUE_ADDR, 8'h00);
				if (m == 0 || m == 3) chk(rd, {2'b11, (m == 0) ? ext_v : v[5:0]});
			end
		end
		// alternate functions take pins 4, 1, 0 and give them back
		{sc_v, tx_v} = 2'($urandom);
		{sc_en, tx_en, rx_en} = 3'h7;
		@(posedge clk_i);
		#2;
		chk({portb_pad_oe_o[4], portb_pad_o[4], portb_pad_oe_o[1], portb_pad_o[1]}, {1'b1, sc_v, 1'b1, tx_v});
		chk({7'h00, portb_pad_oe_o[0]}, 8'h00);
		{sc_en, tx_en, rx_en} = 3'h0;
		#1;
		chk({portb_pad_o[4], portb_pad_o[1], portb_pad_o[0]}, {v[4], v[1], v[0]});
		// port c open-drain pads and status bits
		for (int i = 0; i < 4; i++) begin
			v = (i == 0) ? 8'h00 : 8'($urandom);
			{usb_rdy, shared_select_pad, sda_low} = v[7:5];
			acc(0, 1, `PORTC_VALUE_ADDR, v);
			chk({sda_pad_oe_o, scl_pad_oe_o, sda_pad_o, scl_pad_o}, {!v[1], !v[0], 2'b00});
			acc(0, 0, `PORTC_VALUE_ADDR, 8'h00);
			chk(rd, {5'h1F, v[7], v[1] && !v[5], v[6]});
		end
		// a frozen block ignores writes
		ce_i = 1'b0;
		acc(0, 1, `PORTC_VALUE_ADDR, ~v);
		ce_i = 1'b1;
		chk({6'h00, sda_pad_oe_o, scl_pad_oe_o}, {6'h00, !v[1], !v[0]});
		// host select: copy straps, then every code with pins as inputs
		acc(0, 1, `PORTB_CFG_FIRST_ADDR, 8'h00);
		acc(0, 1, `PORTB_CFG_SECOND_ADDR, 8'h00);
		acc(1, 1, `HOST_SELECT_ADDR, {6'h01, pin1, pin0});
		for (int c = 0; c < 16; c++) begin
			ext_oe = 6'h3F;
			ext_v = 6'($urandom);
			{fs_tx, host_tx, pin0, pin1, usb_drv} = 8'($urandom);
			dp_exp = usb_drv[1] ? usb_drv[0] : host_tx;
			acc(1, 1, `HOST_SELECT_ADDR, {c[3], 4'($urandom), c[2:0]});
			chk({ext_irq_one_o, ext_irq_zero_o}, {ext_v[3] ^ c[3], ext_v[2]});
			chk({usb_en_o, usb_bus_powered_o, fast_serial_en_o}, {c[2] & c[0], c[2] & c[0] & c[1], c[2] & !c[0]});
			if (c[2] && !c[0]) chk({dm_pad_oe_o, dm_pad_o, fast_serial_rx_o}, {1'b1, fs_tx, host_tx});
			if (!c[2]) chk({dp_pad_oe_o, dm_pad_oe_o}, 8'h00);
			if (c[2] && c[0]) chk({usb_dp_o, usb_dm_o, dm_pad_oe_o, dm_pad_o, dp_pad_oe_o, dp_pad_o},
				{dp_exp, usb_drv[3] ? usb_drv[2] : !dp_exp, usb_drv});
			else chk({6'h00, usb_dp_o, usb_dm_o}, 8'h00);
			acc(1, 0, `HOST_SELECT_ADDR, 8'h00);
			chk(rd, {c[3], 1'b0, pin1, 1'b0, pin0, c[2:0]});
		end
		results();
	end
endmodule
